// ---- verilog/audio_out_pkg.sv ----
// Shared constants and types for the audio output path gain control block
package audio_out_pkg;

	localparam int NUM_CH   = 12;
	localparam int SAMPLE_W = 24;
	localparam int REG_W    = 16;
	localparam int FINE_W   = 10;
	localparam int STEP_W   = 17;
	localparam int NCO_W    = 24;
	localparam int ACC_W    = 60;

	// Register map, channel order 1L,1R,2L,2R .. 6L,6R
	localparam logic [REG_W-1:0] ADDR_RAMP   = 16'h0409;
	localparam logic [REG_W-1:0] ADDR_STATUS = 16'h0406;
	localparam logic [REG_W-1:0] CFG_ADDR [NUM_CH] = '{16'h0410, 16'h0414, 16'h0418, 16'h041C,
		16'h0420, 16'h0426, 16'h0428, 16'h042C, 16'h0430, 16'h0434, 16'h0438, 16'h043C};
	localparam logic [REG_W-1:0] VOL_ADDR [NUM_CH] = '{16'h0411, 16'h0415, 16'h0419, 16'h041D,
		16'h0421, 16'h0425, 16'h0429, 16'h042D, 16'h0431, 16'h0435, 16'h0439, 16'h043D};
	localparam int CH_PDM5_LEFT = 8;
	localparam int CH_PDM6_LEFT = 10;

	// Field positions
	localparam int VOL_LSB   = 0;
	localparam int MUTE_BIT  = 8;
	localparam int APPLY_BIT = 9;
	localparam int ANC_LSB   = 10;
	localparam int OSR_BIT   = 13;
	localparam int RISE_LSB  = 0;
	localparam int FALL_LSB  = 4;

	// Reset values
	localparam logic [7:0] VOL_RST  = 8'h80;
	localparam logic       MUTE_RST = 1'b1;
	localparam logic [2:0] RATE_RST = 3'h2;
	localparam logic [1:0] ANC_RST  = 2'h0;
	localparam logic       OSR_RST  = 1'b0;

	localparam logic [1:0] ANC_NONE  = 2'h0;
	localparam logic [1:0] ANC_LEFT  = 2'h1;
	localparam logic [1:0] ANC_RIGHT = 2'h2;

	// Gain law: 0.5 dB codes, 0.125 dB internal steps, 48 steps per 6 dB
	localparam logic [7:0]        VOL_MAX        = 8'hBF;
	localparam int                FINE_SHIFT     = 2;
	localparam logic [FINE_W-1:0] FINE_MUTE      = 10'h000;
	localparam int                FINE_PER_6DB   = 48;
	localparam int                OCT_OFFSET     = 64;
	localparam int                UNITY_OCT      = 12;
	localparam int                MANT_FRAC      = 15;
	localparam int                MANT_ONE       = 32768;
	localparam int                MANT_LIN       = 448;
	localparam int                MANT_SQ_NUM    = 39;
	localparam int                MANT_SQ_SHIFT  = 3;

	// Ramp time per 6 dB in microseconds, step interval is that over 48
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned RAMP_US [8] = '{0, 500, 1000, 2000, 4000, 8000, 15000, 30000};
	localparam int unsigned RAMP_STEP_CYC [8] = '{
		RAMP_US[0] * CLK_MHZ / FINE_PER_6DB, RAMP_US[1] * CLK_MHZ / FINE_PER_6DB,
		RAMP_US[2] * CLK_MHZ / FINE_PER_6DB, RAMP_US[3] * CLK_MHZ / FINE_PER_6DB,
		RAMP_US[4] * CLK_MHZ / FINE_PER_6DB, RAMP_US[5] * CLK_MHZ / FINE_PER_6DB,
		RAMP_US[6] * CLK_MHZ / FINE_PER_6DB, RAMP_US[7] * CLK_MHZ / FINE_PER_6DB};

	// PDM bit clock from a phase accumulator that toggles on carry
	localparam longint CLK_HZ        = 100000000;
	localparam longint PDM_NORM_HZ   = 3072000;
	localparam longint PDM_HP_HZ     = 6144000;
	localparam longint FAMILY_INT_HZ = 6144000;
	localparam longint FAMILY_FRAC_HZ = 5644800;
	localparam longint NCO_ONE       = 64'd1 << NCO_W;
	localparam logic [NCO_W-1:0] PDM_INC [4] = '{
		NCO_W'(2 * PDM_NORM_HZ * NCO_ONE / CLK_HZ),
		NCO_W'(2 * PDM_NORM_HZ * FAMILY_FRAC_HZ / FAMILY_INT_HZ * NCO_ONE / CLK_HZ),
		NCO_W'(2 * PDM_HP_HZ * NCO_ONE / CLK_HZ),
		NCO_W'(2 * PDM_HP_HZ * FAMILY_FRAC_HZ / FAMILY_INT_HZ * NCO_ONE / CLK_HZ)};

	localparam int FIFO_DEPTH = 16;

	typedef logic signed [SAMPLE_W-1:0] sample_t;

	typedef struct packed {
		logic             wr;
		logic             rd;
		logic [REG_W-1:0] addr;
		logic [REG_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		sample_t [NUM_CH-1:0] ch;
		sample_t              anc_left;
		sample_t              anc_right;
	} mix_frame_t;

	typedef struct packed {
		sample_t [NUM_CH-1:0] ch;
	} out_frame_t;

endpackage : audio_out_pkg

// ---- verilog/audio_out_ctrl.sv ----
// Output path gain control: frame FIFO, per-channel gain ramp and the control registers
// Notes on behaviour
// - Status bits 3:0 show paths 2,1 enabled
// - Status set only when enable attempt succeeded
// - All paths share one output sample rate
// - PDM bit clock 3.072 or 6.144 MHz
// - Fractional clock family scales PDM clock
// - Oversample bit 13 in 5L, 6L config
// - Noise-cancel left/right mixable into any channel
// - Source field 11:10: none, left, right, reserved
// - Gain -64 to +31.5 dB, codes above BFh reserved
// - Volume code bits 7:0, reset 80h
// - Mute bit 8 per channel, reset muted
// - Gain changes ramp using rise or fall rate
// - Rate codes: immediate up to 30 ms/6dB
// - Fall rate 6:4, rise rate 2:0, reset 010
// - Writes without update bit only stage values
// - Update bit applies all channels at once
// - Internal gain moves in 0.125 dB steps
`timescale 1ns/100ps

module frame_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;

	assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (in_valid && in_ready) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule : frame_fifo

module path_gain_channel
	import audio_out_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic        [FINE_W-1:0]  target,
	input  wire logic        [STEP_W-1:0]  rise_cyc,
	input  wire logic        [STEP_W-1:0]  fall_cyc,
	input  wire logic                      mute_act,
	input  wire logic signed [SAMPLE_W:0]  sample_in,
	output logic                           [FINE_W-1:0] gain_now,
	output sample_t                        sample_out
);
	localparam logic signed [ACC_W-1:0] POS_LIM = (ACC_W'(1) <<< (SAMPLE_W - 1)) - ACC_W'(1);
	localparam logic signed [ACC_W-1:0] NEG_LIM = -(ACC_W'(1) <<< (SAMPLE_W - 1));

	logic [FINE_W-1:0] cur_q;
	logic [STEP_W-1:0] tick_q;
	logic              up;
	logic [STEP_W-1:0] step_cyc;

	assign up       = target > cur_q;
	assign step_cyc = up ? rise_cyc : fall_cyc;
	assign gain_now = cur_q;

	// Starts at the mute floor since every channel leaves reset muted
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur_q  <= FINE_MUTE;
			tick_q <= '0;
		end else if (cur_q == target) begin
			tick_q <= '0;
		end else if (step_cyc == '0) begin
			cur_q  <= target;
			tick_q <= '0;
		end else if (tick_q >= step_cyc - 1'b1) begin
			tick_q <= '0;
			cur_q  <= up ? cur_q + 1'b1 : cur_q - 1'b1;
		end else begin
			tick_q <= tick_q + 1'b1;
		end
	end

	// Gain = 2^((cur+64)/48 - 12), mantissa by a quadratic fit of 2^x within one octave
	logic        [10:0]      h;
	logic        [4:0]       oct;
	logic        [5:0]       k;
	logic        [16:0]      mant;
	logic signed [ACC_W-1:0] prod;
	logic signed [ACC_W-1:0] scaled;

	always_comb begin
		h      = 11'(cur_q) + 11'(OCT_OFFSET);
		oct    = 5'(h / 11'(FINE_PER_6DB));
		k      = 6'(h % 11'(FINE_PER_6DB));
		mant   = 17'(MANT_ONE) + 17'(MANT_LIN * k) + 17'((MANT_SQ_NUM * k * k) >> MANT_SQ_SHIFT);
		prod   = ACC_W'(sample_in) * $signed({1'b0, mant});
		scaled = (prod <<< oct) >>> (UNITY_OCT + MANT_FRAC);
		if (mute_act && cur_q == FINE_MUTE) begin
			sample_out = '0;
		end else if (scaled > POS_LIM) begin
			sample_out = POS_LIM[SAMPLE_W-1:0];
		end else if (scaled < NEG_LIM) begin
			sample_out = NEG_LIM[SAMPLE_W-1:0];
		end else begin
			sample_out = scaled[SAMPLE_W-1:0];
		end
	end

	property p_single_step;
		@(posedge ref_clk) disable iff (rst)
		(step_cyc != '0 && cur_q != target) |=>
			(cur_q == $past(cur_q) || cur_q == $past(cur_q) + 1'b1 || cur_q == $past(cur_q) - 1'b1);
	endproperty
	a_single_step : assert property (p_single_step) else $error("gain moved more than one step");

	property p_immediate;
		@(posedge ref_clk) disable iff (rst)
		(step_cyc == '0 && cur_q != target) |=> (cur_q == $past(target));
	endproperty
	a_immediate : assert property (p_immediate) else $error("zero rate did not jump");

	property p_step_spacing;
		@(posedge ref_clk) disable iff (rst)
		($changed(cur_q) && step_cyc > 17'd1) |=>
			($stable(cur_q) || $changed(target) || step_cyc == '0);
	endproperty
	a_step_spacing : assert property (p_step_spacing) else $error("gain steps too close");
endmodule : path_gain_channel

module audio_out_ctrl
	import audio_out_pkg::*;
#(
	parameter int unsigned STEP_CYC [8] = audio_out_pkg::RAMP_STEP_CYC
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire audio_out_pkg::reg_req_t  reg_req,
	output logic [audio_out_pkg::REG_W-1:0] reg_rdata,
	input  wire logic [audio_out_pkg::NUM_CH-1:0] path_enable_req,
	input  wire logic [audio_out_pkg::NUM_CH-1:0] path_clock_ok,
	input  wire logic [3:0]               sample_rate_sel,
	input  wire logic                     system_clock_family_sel,
	input  wire logic                     mix_valid,
	output logic                          mix_ready,
	input  wire audio_out_pkg::mix_frame_t mix_frame,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output audio_out_pkg::out_frame_t     out_frame,
	output logic [3:0]                    out_rate,
	output logic [1:0]                    pdm_bit_clock,
	output logic                          pdm5_oversample_sel,
	output logic                          pdm6_oversample_sel,
	output logic [audio_out_pkg::NUM_CH-1:0] path_on_flag
);
	import audio_out_pkg::*;

	logic [2:0]                   rise_q;
	logic [2:0]                   fall_q;
	logic [NUM_CH-1:0][1:0]       anc_q;
	logic                         osr5_q;
	logic                         osr6_q;
	logic [NUM_CH-1:0][7:0]       vol_stage_q;
	logic [NUM_CH-1:0]            mute_stage_q;
	logic [NUM_CH-1:0][7:0]       vol_stage_d;
	logic [NUM_CH-1:0]            mute_stage_d;
	logic [NUM_CH-1:0][7:0]       vol_act_q;
	logic [NUM_CH-1:0]            mute_act_q;
	logic                         apply_wr;
	logic [NUM_CH-1:0]            path_on_q;
	logic [NUM_CH-1:0]            req_q;
	logic [REG_W-1:0]             rdata_q;
	logic [REG_W-1:0]             rdata_d;
	logic                         vol_hit;

	assign pdm5_oversample_sel = osr5_q;
	assign pdm6_oversample_sel = osr6_q;
	assign path_on_flag        = path_on_q;
	assign reg_rdata           = rdata_q;

	// Status in status-bit order: bit 2p-2 is path p left, bit 2p-1 path p right
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			path_on_q <= '0;
			req_q     <= '0;
		end else begin
			req_q     <= path_enable_req;
			// Only a fresh request with enough clock comes up; live paths stay up
			path_on_q <= path_enable_req & (path_on_q | (~req_q & path_clock_ok));
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rise_q <= RATE_RST;
			fall_q <= RATE_RST;
		end else if (reg_req.wr && reg_req.addr == ADDR_RAMP) begin
			rise_q <= reg_req.wdata[RISE_LSB +: 3];
			fall_q <= reg_req.wdata[FALL_LSB +: 3];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			anc_q  <= {NUM_CH{ANC_RST}};
			osr5_q <= OSR_RST;
			osr6_q <= OSR_RST;
		end else if (reg_req.wr) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_req.addr == CFG_ADDR[i]) begin
					anc_q[i] <= reg_req.wdata[ANC_LSB +: 2];
				end
			end
			if (reg_req.addr == CFG_ADDR[CH_PDM5_LEFT]) begin
				osr5_q <= reg_req.wdata[OSR_BIT];
			end
			if (reg_req.addr == CFG_ADDR[CH_PDM6_LEFT]) begin
				osr6_q <= reg_req.wdata[OSR_BIT];
			end
		end
	end

	always_comb begin
		vol_stage_d  = vol_stage_q;
		mute_stage_d = mute_stage_q;
		vol_hit      = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (reg_req.addr == VOL_ADDR[i]) begin
				vol_hit = 1'b1;
				if (reg_req.wr) begin
					vol_stage_d[i]  = reg_req.wdata[VOL_LSB +: 8];
					mute_stage_d[i] = reg_req.wdata[MUTE_BIT];
				end
			end
		end
		apply_wr = reg_req.wr && vol_hit && reg_req.wdata[APPLY_BIT];
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vol_stage_q  <= {NUM_CH{VOL_RST}};
			mute_stage_q <= {NUM_CH{MUTE_RST}};
		end else begin
			vol_stage_q  <= vol_stage_d;
			mute_stage_q <= mute_stage_d;
		end
	end

	// The strobe itself is never stored; the write that carries it is applied too
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vol_act_q  <= {NUM_CH{VOL_RST}};
			mute_act_q <= {NUM_CH{MUTE_RST}};
		end else if (apply_wr) begin
			vol_act_q  <= vol_stage_d;
			mute_act_q <= mute_stage_d;
		end
	end

	always_comb begin
		rdata_d = '0;
		if (reg_req.addr == ADDR_RAMP) begin
			rdata_d[RISE_LSB +: 3] = rise_q;
			rdata_d[FALL_LSB +: 3] = fall_q;
		end
		if (reg_req.addr == ADDR_STATUS) begin
			rdata_d[NUM_CH-1:0] = path_on_q;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (reg_req.addr == CFG_ADDR[i]) begin
				rdata_d[ANC_LSB +: 2] = anc_q[i];
			end
			if (reg_req.addr == VOL_ADDR[i]) begin
				rdata_d[VOL_LSB +: 8] = vol_stage_q[i];
				rdata_d[MUTE_BIT]     = mute_stage_q[i];
			end
		end
		if (reg_req.addr == CFG_ADDR[CH_PDM5_LEFT]) begin
			rdata_d[OSR_BIT] = osr5_q;
		end
		if (reg_req.addr == CFG_ADDR[CH_PDM6_LEFT]) begin
			rdata_d[OSR_BIT] = osr6_q;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (reg_req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	// Audio path: mixer frames queue here so the sink may stall without loss
	mix_frame_t                  fifo_frame;
	logic                        fifo_valid;
	logic                        take;
	logic [STEP_W-1:0]           rise_cyc;
	logic [STEP_W-1:0]           fall_cyc;
	sample_t [NUM_CH-1:0]        gained;
	logic [NUM_CH-1:0]           over_max;
	logic                        out_valid_q;
	out_frame_t                  out_frame_q;
	logic [3:0]                  out_rate_q;

	assign take      = fifo_valid && (!out_valid_q || out_ready);
	assign rise_cyc  = STEP_W'(STEP_CYC[rise_q]);
	assign fall_cyc  = STEP_W'(STEP_CYC[fall_q]);
	assign out_valid = out_valid_q;
	assign out_frame = out_frame_q;
	assign out_rate  = out_rate_q;

	frame_fifo #(
		.WIDTH ($bits(mix_frame_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (mix_valid),
		.in_ready  (mix_ready),
		.in_data   (mix_frame),
		.out_valid (fifo_valid),
		.out_ready (take),
		.out_data  (fifo_frame)
	);

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic signed [SAMPLE_W:0] mixed;
		logic        [FINE_W-1:0] target;
		logic        [7:0]        code;

		always_comb begin
			code   = (vol_act_q[c] > VOL_MAX) ? VOL_MAX : vol_act_q[c];
			target = mute_act_q[c] ? FINE_MUTE : FINE_W'({code, {FINE_SHIFT{1'b0}}});
			mixed  = (SAMPLE_W + 1)'($signed(fifo_frame.ch[c]));
			unique case (anc_q[c])
				ANC_LEFT:  mixed = mixed + (SAMPLE_W + 1)'($signed(fifo_frame.anc_left));
				ANC_RIGHT: mixed = mixed + (SAMPLE_W + 1)'($signed(fifo_frame.anc_right));
				default:   mixed = mixed;
			endcase
		end
		assign over_max[c] = target > FINE_W'({VOL_MAX, {FINE_SHIFT{1'b0}}});

		path_gain_channel u_gain (
			.ref_clk    (ref_clk),
			.rst        (rst),
			.target     (target),
			.rise_cyc   (rise_cyc),
			.fall_cyc   (fall_cyc),
			.mute_act   (mute_act_q[c]),
			.sample_in  (mixed),
			.gain_now   (),
			.sample_out (gained[c])
		);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_valid_q <= 1'b0;
			out_frame_q <= '0;
			out_rate_q  <= '0;
		end else if (take) begin
			out_valid_q <= 1'b1;
			out_frame_q <= out_frame_t'(gained);
			out_rate_q  <= sample_rate_sel;
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	// PDM bit clocks, fractional accumulator gives the right mean rate from ref_clk
	logic [1:0]             pdm_osr;
	logic [1:0][NCO_W-1:0]  phase_q;
	logic [1:0]             pdm_clk_q;

	assign pdm_osr       = {osr6_q, osr5_q};
	assign pdm_bit_clock = pdm_clk_q;

	for (genvar p = 0; p < 2; p++) begin : g_pdm
		logic [NCO_W:0] sum;
		assign sum = {1'b0, phase_q[p]} + {1'b0, PDM_INC[{pdm_osr[p], system_clock_family_sel}]};
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				phase_q[p]   <= '0;
				pdm_clk_q[p] <= 1'b0;
			end else begin
				phase_q[p] <= sum[NCO_W-1:0];
				if (sum[NCO_W]) begin
					pdm_clk_q[p] <= !pdm_clk_q[p];
				end
			end
		end
	end

	property p_on_follows_req;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> ((path_on_q & ~$past(path_enable_req)) == '0);
	endproperty
	a_on_follows_req : assert property (p_on_follows_req) else $error("status on without request");

	property p_on_needs_clock;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> ((path_on_q & ~$past(path_on_q) & ~$past(path_clock_ok)) == '0);
	endproperty
	a_on_needs_clock : assert property (p_on_needs_clock) else $error("status set on failed enable");

	property p_staged_only;
		@(posedge ref_clk) disable iff (rst)
		(!apply_wr) |=> ($stable(vol_act_q) && $stable(mute_act_q));
	endproperty
	a_staged_only : assert property (p_staged_only) else $error("applied gain changed without update");

	property p_apply_all;
		@(posedge ref_clk) disable iff (rst)
		apply_wr |=> (vol_act_q == vol_stage_q && mute_act_q == mute_stage_q);
	endproperty
	a_apply_all : assert property (p_apply_all) else $error("update did not apply all channels");

	property p_apply_reads_zero;
		@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && vol_hit) |=> (reg_rdata[APPLY_BIT] == 1'b0);
	endproperty
	a_apply_reads_zero : assert property (p_apply_reads_zero) else $error("update bit read as one");

	property p_osr5_write;
		@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == CFG_ADDR[CH_PDM5_LEFT]) |=>
			(pdm5_oversample_sel == $past(reg_req.wdata[OSR_BIT]));
	endproperty
	a_osr5_write : assert property (p_osr5_write) else $error("oversample select not written");

	property p_no_reserved_gain;
		@(posedge ref_clk) disable iff (rst)
		(over_max == '0);
	endproperty
	a_no_reserved_gain : assert property (p_no_reserved_gain) else $error("gain target above max");

	property p_rate_follows;
		@(posedge ref_clk) disable iff (rst)
		take |=> (out_valid && out_rate == $past(sample_rate_sel));
	endproperty
	a_rate_follows : assert property (p_rate_follows) else $error("frame rate not latched");
endmodule : audio_out_ctrl

// ---- test/audio_out_sink.sv ----
// Sink model standing in for the DACs and PDM speaker devices
`timescale 1ns/100ps
module audio_out_sink
	import audio_out_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      stall,
	input  wire logic                      out_valid,
	output logic                           out_ready,
	input  wire audio_out_pkg::out_frame_t out_frame,
	input  wire logic [3:0]                out_rate
);
	out_frame_t frames [$];
	logic [3:0] rates [$];

	// A stalled sink holds ready low so the backlog must sit in the buffer
	always @(posedge ref_clk) begin
		if (!rst && out_valid && out_ready) begin
			frames.push_back(out_frame);
			rates.push_back(out_rate);
		end
		out_ready <= #1 !stall && !rst;
	end
endmodule : audio_out_sink

// ---- test/audio_out_ctrl_tb.sv ----
// Self-checking bench for the output path gain control block
`timescale 1ns/100ps
module audio_out_ctrl_tb;
	import audio_out_pkg::*;
	localparam int unsigned STEPS [8] = '{0, 2, 3, 4, 5, 6, 7, 8};
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	reg_req_t          reg_req = '0;
	logic [REG_W-1:0]  reg_rdata;
	logic [NUM_CH-1:0] path_enable_req = '0;
	logic [NUM_CH-1:0] path_clock_ok = '0;
	logic [NUM_CH-1:0] path_on_flag;
	logic [3:0]        sample_rate_sel = 4'h5;
	logic              fam = 1'b0;
	logic              mix_valid = 1'b0;
	logic              mix_ready, out_valid, out_ready, prev, prev6;
	logic              stall = 1'b0;
	mix_frame_t        mix_frame = '0;
	out_frame_t        out_frame;
	logic [3:0]        out_rate;
	logic [1:0]        pdm_bit_clock;
	logic              pdm5_oversample_sel, pdm6_oversample_sel;
	int                mismatches = 0, compares = 0, cycles = 0, n, e, base, n6;

	always #5 ref_clk = ~ref_clk;

	audio_out_ctrl #(.STEP_CYC(STEPS)) audio_out_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .path_enable_req(path_enable_req),
		.path_clock_ok(path_clock_ok), .sample_rate_sel(sample_rate_sel),
		.system_clock_family_sel(fam), .mix_valid(mix_valid), .mix_ready(mix_ready),
		.mix_frame(mix_frame), .out_valid(out_valid), .out_ready(out_ready),
		.out_frame(out_frame), .out_rate(out_rate), .pdm_bit_clock(pdm_bit_clock),
		.pdm5_oversample_sel(pdm5_oversample_sel), .pdm6_oversample_sel(pdm6_oversample_sel),
		.path_on_flag(path_on_flag));

	audio_out_sink sink_inst (.ref_clk(ref_clk), .rst(rst), .stall(stall),
		.out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame),
		.out_rate(out_rate));

	task automatic step(input int k = 1);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : step

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	// An idle cycle follows each access so the strobe is never set twice in one step
	task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
		reg_req = '{1'b1, 1'b0, a, d};
		step();
		reg_req = '0;
		step();
	endtask : reg_write

	task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
		reg_req = '{1'b0, 1'b1, a, 16'h0000};
		step();
		reg_req = '0;
		chk(reg_rdata, exp, "register read");
		step();
	endtask : reg_read

	task automatic push(input int v, input int a);
		int k;
		k = sink_inst.frames.size();
		mix_frame.ch[0] = sample_t'(v);
		mix_frame.ch[1] = sample_t'(v);
		mix_frame.ch[5] = sample_t'(v);
		mix_frame.anc_left = sample_t'(a);
		mix_frame.anc_right = sample_t'(2 * a);
		mix_valid = 1'b1;
		step();
		mix_valid = 1'b0;
		n = 0;
		while (sink_inst.frames.size() == k && n < 20) begin
			step();
			n++;
		end
		chk(n < 20, 1, "frame delivered");
	endtask : push

	task automatic wrap_up();
		if (mismatches == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		step(3);
		rst = 1'b0;
		step();
		reg_read(ADDR_RAMP, 16'h0022);
		reg_read(VOL_ADDR[0], 16'h0180);
		reg_read(CFG_ADDR[8], 16'h0000);
		reg_read(16'h0500, 16'h0000);
		reg_write(ADDR_RAMP, 16'h0000);
		reg_write(VOL_ADDR[0], 16'h0080);
		reg_write(CFG_ADDR[0], 16'h0400);
		reg_write(CFG_ADDR[5], 16'h0800);
		reg_write(VOL_ADDR[1], 16'h01C5);
		reg_read(VOL_ADDR[1], 16'h01C5);
		push(100, 20);
		chk(sink_inst.frames[$].ch[0], 0, "staged");
		reg_write(VOL_ADDR[5], 16'h0280);
		reg_read(VOL_ADDR[5], 16'h0080);
		push(100, 20);
		chk(sink_inst.frames[$].ch[0], 120, "left");
		chk(sink_inst.frames[$].ch[5], 140, "right");
		chk(sink_inst.frames[$].ch[1], 0, "muted");
		chk(sink_inst.rates[$], 4'h5, "rate");
		// Fill while the sink stalls, then drain and check order
		mix_frame = '0;
		stall = 1'b1;
		base = sink_inst.frames.size();
		for (n = 0; n < 20 && mix_ready === 1'b1; n++) begin
			mix_frame.ch[0] = sample_t'(n);
			mix_valid = 1'b1;
			step();
		end
		mix_valid = 1'b0;
		e = n;
		chk(e >= FIFO_DEPTH, 1, "depth");
		chk(mix_ready, 0, "full refused");
		stall = 1'b0;
		step(40);
		for (n = 0; n < e; n++) chk(sink_inst.frames[base + n].ch[0], n, "order");
		// Mute ramps down at one fine step per three cycles
		reg_write(ADDR_RAMP, 16'h0022);
		reg_write(VOL_ADDR[0], 16'h0380);
		push(100000, 0);
		chk(sink_inst.frames[$].ch[0] != '0, 1, "ramp start");
		step(1190);
		push(100000, 0);
		chk(sink_inst.frames[$].ch[0] != '0, 1, "ramp middle");
		step(400);
		push(100000, 0);
		chk(sink_inst.frames[$].ch[0], 0, "ramp end");
		// Ramps have settled, so the rates may change again
		reg_write(ADDR_RAMP, 16'h0000);
		reg_write(VOL_ADDR[1], 16'h02C5);
		sample_rate_sel = 4'hA;
		push(1000, 0);
		// A reserved code must stop at +31.5 dB, about 37.6 times
		e = sink_inst.frames[$].ch[1];
		chk(e > 36700 && e < 38500, 1, "clamped gain");
		chk(sink_inst.rates[$], 4'hA, "rate change");
		path_clock_ok = 12'h001;
		path_enable_req = 12'h003;
		step(2);
		chk(path_on_flag, 12'h001, "clock starved");
		reg_read(ADDR_STATUS, 16'h0001);
		path_enable_req = 12'h000;
		path_clock_ok = 12'h00F;
		step(2);
		path_enable_req = 12'h00E;
		step(2);
		reg_read(ADDR_STATUS, 16'h000E);
		for (int m = 0; m < 4; m++) begin
			reg_write(CFG_ADDR[CH_PDM5_LEFT], m[0] ? 16'h2000 : 16'h0000);
			reg_write(CFG_ADDR[CH_PDM6_LEFT], m[0] ? 16'h2000 : 16'h0000);
			fam = m[1];
			step(50);
			chk(pdm5_oversample_sel, m[0], "osr5");
			chk(pdm6_oversample_sel, m[0], "osr6");
			e = (3072 << m[0]) * (m[1] ? 147 : 160) / 16000;
			n = 0;
			n6 = 0;
			prev = pdm_bit_clock[0];
			prev6 = pdm_bit_clock[1];
			repeat (1000) begin
				step();
				if (pdm_bit_clock[0] && !prev) n++;
				if (pdm_bit_clock[1] && !prev6) n6++;
				prev = pdm_bit_clock[0];
				prev6 = pdm_bit_clock[1];
			end
			chk(n == e || n == e + 1, 1, "bit clock rate");
			chk(n6 == e || n6 == e + 1, 1, "path 6 bit clock rate");
		end
		wrap_up();
	end
endmodule : audio_out_ctrl_tb
